// >>> verilog/rlmb_pkg.sv
package rlmb_pkg;

  // avalon register map, byte addresses of 32-bit words
  localparam int unsigned RLMB_ADDR_W       = 4;
  localparam logic [3:0]  RLMB_OFS_CTRL     = 4'h0;
  localparam logic [3:0]  RLMB_OFS_STATUS   = 4'h4;
  localparam logic [3:0]  RLMB_OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0]  RLMB_OFS_IRQ_MASK = 4'hC;

  // control register fields
  localparam int unsigned RLMB_CTRL_SWEEP_ALLOW = 0;
  localparam int unsigned RLMB_CTRL_MUTE_FORCE  = 1;
  localparam int unsigned RLMB_CTRL_W           = 2;
  localparam logic [1:0]  RLMB_CTRL_RESET       = 2'h1;

  // status register fields
  localparam int unsigned RLMB_ST_LOCK       = 0;
  localparam int unsigned RLMB_ST_PHASE_LOCK = 1;
  localparam int unsigned RLMB_ST_SAT_LOW    = 2;
  localparam int unsigned RLMB_ST_SAT_HIGH   = 3;
  localparam int unsigned RLMB_ST_SWEEP_EN   = 4;
  localparam int unsigned RLMB_ST_SWEEP_UP   = 5;
  localparam int unsigned RLMB_ST_MUTE       = 6;
  localparam int unsigned RLMB_ST_BYPASS     = 7;
  localparam int unsigned RLMB_ST_W          = 8;

  // interrupt event bits, shared by status and mask
  localparam int unsigned RLMB_EV_LOCK_GAIN = 0;
  localparam int unsigned RLMB_EV_LOCK_LOSS = 1;
  localparam int unsigned RLMB_EV_REVERSE   = 2;
  localparam int unsigned RLMB_EV_W         = 3;
  localparam logic [2:0]  RLMB_EV_RESET     = 3'h0;

  localparam logic [31:0] RLMB_RD_UNMAPPED = 32'h0000_0000;

  // integrator saturation indications
  typedef struct packed {
    logic sat_high;
    logic sat_low;
  } rlmb_level_t;

  // pin inputs that cross into the clock domain
  typedef struct packed {
    logic        bypass_n;
    logic        phase_lock;
    rlmb_level_t level;
  } rlmb_pins_t;

  localparam int unsigned RLMB_PINS_W     = 4;
  localparam logic [3:0]  RLMB_PINS_RESET = 4'h8;

  // sweep drive towards the integrator summing node
  typedef struct packed {
    logic enable;
    logic up;
  } rlmb_sweep_t;

endpackage

// >>> verilog/rlmb_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rlmb_sync
  import rlmb_pkg::*;
#(
  parameter int unsigned  W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         clk,    // system clock
  input  wire logic         reset,  // synchronous, active high
  input  wire logic [W-1:0] async_in, // asynchronous levels
  output logic      [W-1:0] sync_out  // filtered, clock-domain levels
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic out_reg;
      logic out_next;

      // change accepted only when stages two and three agree
      assign out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;

      always_ff @(posedge clk) begin
        if (reset) begin
          s1_reg  <= RESET_VAL[i];
          s2_reg  <= RESET_VAL[i];
          s3_reg  <= RESET_VAL[i];
          out_reg <= RESET_VAL[i];
        end else begin
          s1_reg  <= async_in[i];
          s2_reg  <= s1_reg;
          s3_reg  <= s2_reg;
          out_reg <= out_next;
        end
      end

      assign sync_out[i] = out_reg;
    end
  endgenerate

endmodule

`default_nettype wire

// >>> verilog/rlmb_top.sv
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module rlmb_top
  import rlmb_pkg::*;
(
  input  wire logic                   clk,                   // 20 MHz clock
  input  wire logic                   reset,                 // synchronous, active high
  input  wire logic                   serial_in,             // serial data input pin
  input  wire logic                   phase_lock_in,         // phase-lock indication pin
  input  wire rlmb_level_t            loop_integrator_level, // integrator saturation pins
  input  wire logic                   bypass_n,              // bypass, active low pin
  output logic                        serial_out,            // serial data output
  output logic                        serial_out_n,          // complementary output
  output logic                        pll_lock,              // lock flag
  output rlmb_sweep_t                 sweep,                 // sweep current control
  output logic                        mute,                  // mute active
  output logic                        irq,                   // level interrupt
  input  wire logic [RLMB_ADDR_W-1:0] avs_address,           // byte address
  input  wire logic                   avs_read,              // read request
  input  wire logic                   avs_write,             // write request
  input  wire logic [31:0]            avs_writedata,         // write data
  input  wire logic [3:0]             avs_byteenable,        // byte enables
  output logic [31:0]                 avs_readdata,          // read data
  output logic                        avs_waitrequest        // stall
);

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  // input synchronisation
  rlmb_pins_t pins_raw;
  rlmb_pins_t pins_s;
  logic [RLMB_PINS_W-1:0] pins_s_bits;

  assign pins_raw.bypass_n   = bypass_n;
  assign pins_raw.phase_lock = phase_lock_in;
  assign pins_raw.level      = loop_integrator_level;

  rlmb_sync #(
    .W         (RLMB_PINS_W),
    .RESET_VAL (RLMB_PINS_RESET)
  ) u_sync_pins (
    .clk      (clk),
    .reset    (reset),
    .async_in (pins_raw),
    .sync_out (pins_s_bits)
  );

  assign pins_s = rlmb_pins_t'(pins_s_bits);

  logic data_s;

  rlmb_sync #(
    .W         (1),
    .RESET_VAL (1'b0)
  ) u_sync_data (
    .clk      (clk),
    .reset    (reset),
    .async_in (serial_in),
    .sync_out (data_s)
  );

  // lock logic
  wire no_data     = pins_s.level.sat_high | pins_s.level.sat_low;
  wire bypass_on   = ~pins_s.bypass_n;
  wire lock_next   = pins_s.phase_lock & ~no_data;

  logic lock_reg;
  logic sat_any_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      lock_reg    <= 1'b0;
      sat_any_reg <= 1'b0;
    end else begin
      lock_reg    <= lock_next;
      sat_any_reg <= no_data;
    end
  end

  assign pll_lock = lock_reg;

  // sweep control
  logic [RLMB_CTRL_W-1:0] ctrl_reg;
  logic                   sweep_up_reg;
  logic                   sweep_en_reg;

  wire sweep_allow = ctrl_reg[RLMB_CTRL_SWEEP_ALLOW];
  wire sweep_en_next = sweep_allow & ~pins_s.phase_lock;
  wire reverse_ev    = sweep_en_reg & rise(no_data, sat_any_reg);
  wire sweep_up_next = reverse_ev ? ~sweep_up_reg : sweep_up_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      sweep_en_reg <= 1'b0;
      sweep_up_reg <= 1'b1;
    end else begin
      sweep_en_reg <= sweep_en_next;
      sweep_up_reg <= sweep_up_next;
    end
  end

  assign sweep.enable = sweep_en_reg;
  assign sweep.up     = sweep_up_reg;

  // mute and retime path
  wire mute_force = ctrl_reg[RLMB_CTRL_MUTE_FORCE];
  wire mute_cond  = ~lock_reg | mute_force;
  wire mute_eff   = mute_cond & ~bypass_on;

  logic retime_reg;
  logic retime_next;

  assign retime_next = mute_cond ? retime_reg : data_s;

  always_ff @(posedge clk) begin
    if (reset) begin
      retime_reg <= 1'b0;
    end else begin
      retime_reg <= retime_next;
    end
  end

  // bypass taps the pin ahead of any clocked stage
  assign serial_out   = bypass_on ? serial_in : retime_reg;
  assign serial_out_n = ~serial_out;
  assign mute         = mute_eff;

  // interrupt events
  logic lock_prev_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      lock_prev_reg <= 1'b0;
    end else begin
      lock_prev_reg <= lock_reg;
    end
  end

  logic [RLMB_EV_W-1:0] ev_now;

  assign ev_now[RLMB_EV_LOCK_GAIN] = rise(lock_reg, lock_prev_reg);
  assign ev_now[RLMB_EV_LOCK_LOSS] = rise(lock_prev_reg, lock_reg);
  assign ev_now[RLMB_EV_REVERSE]   = reverse_ev;

  // avalon slave: one wait cycle, answer on second edge
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [RLMB_EV_W-1:0] irq_stat_reg;
  logic [RLMB_EV_W-1:0] irq_mask_reg;

  wire req        = avs_read | avs_write;
  wire wr_fire    = avs_write & ack_reg;
  wire sel_ctrl   = (avs_address == RLMB_OFS_CTRL);
  wire sel_status = (avs_address == RLMB_OFS_STATUS);
  wire sel_istat  = (avs_address == RLMB_OFS_IRQ_STAT);
  wire sel_imask  = (avs_address == RLMB_OFS_IRQ_MASK);
  wire be0        = avs_byteenable[0];

  assign avs_waitrequest = req & ~ack_reg;

  logic [RLMB_ST_W-1:0] status_word;

  assign status_word[RLMB_ST_LOCK]       = lock_reg;
  assign status_word[RLMB_ST_PHASE_LOCK] = pins_s.phase_lock;
  assign status_word[RLMB_ST_SAT_LOW]    = pins_s.level.sat_low;
  assign status_word[RLMB_ST_SAT_HIGH]   = pins_s.level.sat_high;
  assign status_word[RLMB_ST_SWEEP_EN]   = sweep_en_reg;
  assign status_word[RLMB_ST_SWEEP_UP]   = sweep_up_reg;
  assign status_word[RLMB_ST_MUTE]       = mute_eff;
  assign status_word[RLMB_ST_BYPASS]     = bypass_on;

  logic [31:0] rd_mux;

  assign rd_mux = sel_ctrl   ? {{(32-RLMB_CTRL_W){1'b0}}, ctrl_reg} :
                  sel_status ? {{(32-RLMB_ST_W){1'b0}}, status_word} :
                  sel_istat  ? {{(32-RLMB_EV_W){1'b0}}, irq_stat_reg} :
                  sel_imask  ? {{(32-RLMB_EV_W){1'b0}}, irq_mask_reg} :
                  RLMB_RD_UNMAPPED;

  wire [RLMB_CTRL_W-1:0] ctrl_next =
    (wr_fire & sel_ctrl & be0) ? avs_writedata[RLMB_CTRL_W-1:0] : ctrl_reg;
  wire [RLMB_EV_W-1:0] mask_next =
    (wr_fire & sel_imask & be0) ? avs_writedata[RLMB_EV_W-1:0] : irq_mask_reg;
  wire [RLMB_EV_W-1:0] clr_bits =
    (wr_fire & sel_istat & be0) ? avs_writedata[RLMB_EV_W-1:0] : RLMB_EV_RESET;
  // a new event wins over a simultaneous clear
  wire [RLMB_EV_W-1:0] stat_next = (irq_stat_reg & ~clr_bits) | ev_now;

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_reg      <= 1'b0;
      rdata_reg    <= RLMB_RD_UNMAPPED;
      ctrl_reg     <= RLMB_CTRL_RESET;
      irq_mask_reg <= RLMB_EV_RESET;
      irq_stat_reg <= RLMB_EV_RESET;
    end else begin
      ack_reg      <= req & ~ack_reg;
      rdata_reg    <= (avs_read & ~ack_reg) ? rd_mux : rdata_reg;
      ctrl_reg     <= ctrl_next;
      irq_mask_reg <= mask_next;
      irq_stat_reg <= stat_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign irq          = |(irq_stat_reg & irq_mask_reg);

endmodule

`default_nettype wire

// >>> tb/rlmb_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rlmb_top_asserts
  import rlmb_pkg::*;
(
  input wire logic        clk,                   // clock
  input wire logic        reset,                 // sync reset
  input wire logic        serial_in,             // data pin
  input wire logic        phase_lock_in,         // phase pin
  input wire rlmb_level_t loop_integrator_level, // sat pins
  input wire logic        bypass_n,              // bypass pin
  input wire logic        serial_out,            // data out
  input wire logic        serial_out_n,          // inverted out
  input wire logic        pll_lock,              // lock flag
  input wire rlmb_sweep_t sweep,                 // sweep drive
  input wire logic        mute                   // mute
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire logic sat = |loop_integrator_level;
  property p_lock_on; (phase_lock_in && !sat)[*7] |-> pll_lock; endproperty
  property p_no_data; sat[*7] |-> !pll_lock; endproperty
  property p_sweep_stop; phase_lock_in[*7] |-> !sweep.enable; endproperty
  property p_reverse;
    (!phase_lock_in && !sat)[*6] ##1 (!phase_lock_in && sat)[*8] |-> sweep.up != $past(sweep.up, 8);
  endproperty
  property p_mute_on; bypass_n[*6] ##0 !pll_lock |-> mute; endproperty
  property p_hold; mute[*2] |-> $stable(serial_out); endproperty
  property p_byp_route; (!bypass_n)[*6] |-> serial_out == serial_in && serial_out_n != serial_in;
  endproperty
  property p_byp_nomute; (!bypass_n)[*6] |-> !mute; endproperty
  a_lock_on: assert property (p_lock_on) else $error("lock flag missing");
  a_no_data: assert property (p_no_data) else $error("lock with saturation");
  a_sweep_stop: assert property (p_sweep_stop) else $error("sweep while locked");
  a_reverse: assert property (p_reverse) else $error("sweep not reversed");
  a_mute_on: assert property (p_mute_on) else $error("no mute when unlocked");
  a_hold: assert property (p_hold) else $error("muted output moved");
  a_byp_route: assert property (p_byp_route) else $error("bypass not routed");
  a_byp_nomute: assert property (p_byp_nomute) else $error("mute in bypass");
  c_lock: cover property (!pll_lock ##1 pll_lock);
  c_hold: cover property (mute[*4]);
  c_byp: cover property ((!bypass_n)[*8]);
endmodule
bind rlmb_top rlmb_top_asserts chk_u (.clk, .reset, .serial_in, .phase_lock_in,
  .loop_integrator_level, .bypass_n, .serial_out, .serial_out_n, .pll_lock, .sweep, .mute);
`default_nettype wire

// >>> tb/rlmb_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module rlmb_src_model
  import rlmb_pkg::*;
(
  input  wire logic       clk,      // clock
  input  wire logic       lock_req, // wanted phase lock
  input  wire logic [1:0] sat_req,  // wanted saturation, high end first
  input  wire logic       data_req, // next serial bit
  output logic            phase_lock, // phase-lock pin
  output rlmb_level_t     level,    // saturation pins
  output logic            data      // serial pin
);
  initial begin
    phase_lock = 1'b0;
    level = '0;
    data = 1'b0;
  end
  // pins lag the bench by one edge, like a slow analog source
  always @(posedge clk) begin
    phase_lock <= lock_req;
    level <= sat_req;
    data <= data_req;
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rlmb_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        lock_req = 1'b0;
  logic [1:0]  sat_req = 2'h0;
  logic        data_req = 1'b0;
  logic        bypass_n = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  localparam logic [31:0] ST_SEARCH = 32'((1 << RLMB_ST_SAT_HIGH) | (1 << RLMB_ST_SWEEP_EN)
                                          | (1 << RLMB_ST_SWEEP_UP) | (1 << RLMB_ST_MUTE));
  logic [31:0] avs_readdata, rd;
  logic        serial_in, phase_lock_in, serial_out, serial_out_n, pll_lock, mute, irq;
  logic        avs_waitrequest, hv;
  rlmb_level_t loop_integrator_level;
  rlmb_sweep_t sweep;
  int          err_count = 0;
  int          checked = 0;
  initial begin
    forever #25 clk = ~clk;
  end
  rlmb_src_model src_u (.clk, .lock_req, .sat_req, .data_req, .phase_lock(phase_lock_in),
    .level(loop_integrator_level), .data(serial_in));
  rlmb_top dut_u (.clk, .reset, .serial_in, .phase_lock_in, .loop_integrator_level, .bypass_n,
    .serial_out, .serial_out_n, .pll_lock, .sweep, .mute, .irq, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [2:0] exp_pins(logic p, logic [1:0] s, logic b);
    logic lk;
    lk = p && (s == 2'h0);
    return {lk, !lk && b, !p};
  endfunction
  task tick(input int n);
    repeat (n) begin
      @(posedge clk);
      data_req <= 1'($urandom);
    end
  endtask
  task pins(input logic p, input logic [1:0] s, input logic b);
    lock_req <= p;
    sat_req <= s;
    bypass_n <= b;
    tick(9);
    @(negedge clk);
    chk("lock mute sweep", {pll_lock, mute, sweep.enable}, exp_pins(p, s, b));
    tick(1);
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    logic wt;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // read right after the edge: values are those the edge sampled
    do begin
      @(posedge clk);
      wt = avs_waitrequest;
      rd = avs_readdata;
      n++;
    end while (wt !== 1'b0 && n < 20);
    if (wt !== 1'b0) chk("waitrequest", wt, 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task print_verdict;
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict;
  end
  initial begin
    void'($urandom(37));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    tick(1);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    rdc("ctrl", RLMB_OFS_CTRL, 32'(RLMB_CTRL_RESET));
    avs_byteenable <= 4'hE;
    bus(1'b1, RLMB_OFS_IRQ_MASK, 32'h7);
    avs_byteenable <= 4'hF;
    rdc("mask", RLMB_OFS_IRQ_MASK, 32'h0);
    rdc("unmapped", 4'h2, RLMB_RD_UNMAPPED);
    $display("end of test: registers");
    bus(1'b1, RLMB_OFS_IRQ_MASK, 32'h7);
    pins(1'b1, 2'h0, 1'b1);
    chk("irq", irq, 1'b1);
    rdc("irq stat", RLMB_OFS_IRQ_STAT, 32'h1);
    bus(1'b1, RLMB_OFS_IRQ_STAT, 32'h1);
    chk("irq", irq, 1'b0);
    bus(1'b1, RLMB_OFS_IRQ_MASK, 32'h0);
    pins(1'b1, 2'h2, 1'b1);
    chk("masked irq", irq, 1'b0);
    rdc("irq stat", RLMB_OFS_IRQ_STAT, 32'h2);
    bus(1'b1, RLMB_OFS_IRQ_MASK, 32'h7);
    chk("irq", irq, 1'b1);
    bus(1'b1, RLMB_OFS_IRQ_STAT, 32'h7);
    chk("irq", irq, 1'b0);
    $display("end of test: interrupts");
    hv = serial_out;
    tick(12);
    chk("held output", serial_out, hv);
    for (int i = 0; i < 2; i++) begin
      pins(1'b0, 2'h0, 1'b1);
      hv = sweep.up;
      pins(1'b0, 2'(1 << i), 1'b1);
      chk("sweep dir", sweep.up, !hv);
    end
    rdc("irq stat", RLMB_OFS_IRQ_STAT, 32'h4);
    bus(1'b1, RLMB_OFS_IRQ_STAT, 32'h7);
    rdc("status", RLMB_OFS_STATUS, ST_SEARCH);
    bus(1'b1, RLMB_OFS_CTRL, 32'h0);
    tick(1);
    chk("sweep allow", sweep.enable, 1'b0);
    bus(1'b1, RLMB_OFS_CTRL, 32'(RLMB_CTRL_RESET));
    $display("end of test: sweep");
    repeat (10) pins(1'($urandom), 2'($urandom), 1'($urandom));
    pins(1'b0, 2'h0, 1'b0);
    repeat (8) begin
      @(negedge clk);
      chk("bypass out", serial_out, serial_in);
      chk("bypass out n", serial_out_n, !serial_in);
      tick(1);
    end
    pins(1'b1, 2'h0, 1'b0);
    $display("end of test: bypass");
    pins(1'b1, 2'h0, 1'b1);
    bus(1'b1, RLMB_OFS_CTRL, 32'h3);
    chk("forced mute", mute, 1'b1);
    bus(1'b1, RLMB_OFS_CTRL, 32'h1);
    $display("end of test: forced mute");
    print_verdict;
  end
endmodule
`default_nettype wire
